// >>> logic/pulse_counter_consts.svh
`ifndef PULSE_COUNTER_CONSTS_SVH
`define PULSE_COUNTER_CONSTS_SVH

`define CNT_WIDTH        32
`define CNT_ZERO         32'h0000_0000
`define CNT_ONE          32'h0000_0001
`define RUN_RESET        1'b1
`define CLR_RESET        1'b0
`define OVF_RESET        1'b0
`define SPARE_VALUE      1'b0
`define EDGE_RESET       1'b0
`define REJ_RESET        1'b0

`endif

// >>> logic/pulse_counter_pkg.sv
package pulse_counter_pkg;

  // alarm mode as written by the host
  typedef enum logic [1:0] {
    ALARM_DISABLE,
    ALARM_MOMENTARY,
    ALARM_LATCH,
    ALARM_RSVD
  } alarm_mode_t;

  // per-channel control and status flags, last flag in bit 0
  typedef struct packed {
    logic spare;
    logic overflow;
    logic clear_req;
    logic run;
  } chan_flags_t;

  // host alarm setup
  typedef struct packed {
    alarm_mode_t mode;
    logic [31:0] high_limit;
    logic [31:0] low_limit;
  } alarm_cfg_t;

endpackage : pulse_counter_pkg

// >>> logic/limit_alarm.sv
`timescale 1ns/1ps
`include "pulse_counter_consts.svh"

module limit_alarm
  import pulse_counter_pkg::*;
#(
  parameter int WIDTH         = `CNT_WIDTH,
  parameter bit ALLOW_MOMENT  = 1'b1
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // monitored value and setup
  input  wire logic [WIDTH-1:0] value,
  input  wire alarm_mode_t      mode,
  input  wire logic [WIDTH-1:0] high_limit,
  input  wire logic [WIDTH-1:0] low_limit,
  input  wire logic             clear_latch,
  // alarm result
  output logic                  alarm,
  output logic                  violation
);
  import pulse_counter_pkg::*;

  logic        out_reg;
  logic        prev_viol_reg;
  logic        viol;
  logic        moment_ok;

  assign moment_ok = ALLOW_MOMENT;
  assign viol      = (value > high_limit) || (value < low_limit);
  assign alarm     = out_reg;
  assign violation = prev_viol_reg;

  ////////////////////////////////////////////////////////////////////////
  // excursion tracking
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      prev_viol_reg <= 1'b0;
    else
      prev_viol_reg <= viol && (mode != ALARM_DISABLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm output
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      out_reg <= 1'b0;
    else
    begin
      case (mode)
        ALARM_DISABLE:
          out_reg <= 1'b0;
        ALARM_MOMENTARY:
          out_reg <= moment_ok && viol && !prev_viol_reg;
        ALARM_LATCH:
          // a new violation wins over a clear in the same cycle
          if (viol)
            out_reg <= 1'b1;
          else if (clear_latch)
            out_reg <= 1'b0;
        default:
          out_reg <= 1'b0;
      endcase
    end
  end

endmodule : limit_alarm

// >>> logic/pulse_counter_channel.sv
`timescale 1ns/1ps
`include "pulse_counter_consts.svh"

// Functional notes
// - channel shows 32-bit unsigned count plus four flags; fourth flag unused
// - run flag resets to 1; 1 counts, 0 stops, 1 resumes
// - clear flag reads 0; host pulse to 1 zeroes counter, flag returns 0
// - overflow flag set by wrap, held until host writes 0
// - alarm compares value with high and low limits, drives digital output
// - disabled mode does no checking and never asserts alarm
// - momentary mode alarms once per limit excursion
// - latch mode holds alarm until host clear-latch command
// - counter channels allow only disabled and latch modes
module pulse_counter_channel
  import pulse_counter_pkg::*;
#(
  parameter int WIDTH = `CNT_WIDTH
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // pulse input, synchronous to clk_sys
  input  wire logic             pulse_in,
  // host flag writes
  input  wire logic             run_wr,
  input  wire logic             run_wdata,
  input  wire logic             clear_wr,
  input  wire logic             clear_wdata,
  input  wire logic             ovf_wr,
  input  wire logic             ovf_wdata,
  // host alarm setup
  input  wire pulse_counter_pkg::alarm_cfg_t alarm_cfg,
  input  wire logic             clear_latch,
  // channel state
  output logic [WIDTH-1:0]      count,
  output pulse_counter_pkg::chan_flags_t flags,
  output logic                  alarm_out,
  output logic                  mode_rejected
);
  import pulse_counter_pkg::*;

  // counter state
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             wrap;
  // host flags
  logic             run_reg;
  logic             ovf_reg;
  logic             clear_pulse;
  logic             ovf_clear;
  // input edge
  logic             pulse_d_reg;
  logic             rise;
  logic             take_pulse;
  // alarm mode
  alarm_mode_t      eff_mode;
  logic             mode_bad;
  logic             rej_reg;
  chan_flags_t      flags_view;

  ////////////////////////////////////////////////////////////////////////
  // input edge qualification
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pulse_d_reg <= `EDGE_RESET;
    end
    else
    begin
      pulse_d_reg <= pulse_in;
    end
  end

  // a level already high at reset release counts as one rise
  assign rise       = pulse_in && !pulse_d_reg;
  assign take_pulse = run_reg && rise;

  ////////////////////////////////////////////////////////////////////////
  // run control
  // a stop takes effect on the edge after the write
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_reg <= `RUN_RESET;
    end
    else if (run_wr)
    begin
      run_reg <= run_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host strobes
  // clear only acts on a written 1; a written 0 leaves the count alone
  assign clear_pulse = clear_wr && clear_wdata;
  // overflow only clears on a written 0; a written 1 is ignored
  assign ovf_clear   = ovf_wr && !ovf_wdata;

  ////////////////////////////////////////////////////////////////////////
  // count value; clear has priority over a pulse in the same cycle
  // only wrap compares against all ones; the count update is a plain increment
  assign count_next = count_reg + WIDTH'(`CNT_ONE);
  assign wrap       = take_pulse && (count_reg == {WIDTH{1'b1}});

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_reg <= WIDTH'(`CNT_ZERO);
    end
    else if (clear_pulse)
    begin
      count_reg <= WIDTH'(`CNT_ZERO);
    end
    else if (take_pulse)
    begin
      // all ones rolls over to zero here
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overflow flag; a wrap wins over a host clear in the same cycle
  // the flag stays set across a clear of the count
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovf_reg <= `OVF_RESET;
    end
    else if (wrap)
    begin
      ovf_reg <= 1'b1;
    end
    else if (ovf_clear)
    begin
      ovf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm mode filter: momentary and reserved are refused, act as disabled
  always_comb
  begin
    eff_mode = ALARM_DISABLE;
    mode_bad = 1'b0;
    case (alarm_cfg.mode)
      ALARM_DISABLE:
      begin
        eff_mode = ALARM_DISABLE;
        mode_bad = 1'b0;
      end
      ALARM_LATCH:
      begin
        eff_mode = ALARM_LATCH;
        mode_bad = 1'b0;
      end
      ALARM_MOMENTARY:
      begin
        eff_mode = ALARM_DISABLE;
        mode_bad = 1'b1;
      end
      ALARM_RSVD:
      begin
        eff_mode = ALARM_DISABLE;
        mode_bad = 1'b1;
      end
      default:
      begin
        eff_mode = ALARM_DISABLE;
        mode_bad = 1'b1;
      end
    endcase
  end

  // refusal is reported one cycle later, in step with the alarm output
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rej_reg <= `REJ_RESET;
    end
    else
    begin
      rej_reg <= mode_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limit alarm; the momentary path stays switched off on a counter
  // the alarm watches the registered count, so it trails a count change by one cycle
  limit_alarm #(
    .WIDTH        (WIDTH),
    .ALLOW_MOMENT (1'b0)
  ) u_alarm (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .value        (count_reg),
    .mode         (eff_mode),
    .high_limit   (alarm_cfg.high_limit[WIDTH-1:0]),
    .low_limit    (alarm_cfg.low_limit[WIDTH-1:0]),
    .clear_latch  (clear_latch),
    .alarm        (alarm_out),
    .violation    ()
  );

  ////////////////////////////////////////////////////////////////////////
  // channel read-back
  // the clear flag always reads 0: the clear acts in the cycle it is written
  always_comb
  begin
    flags_view           = '0;
    flags_view.run       = run_reg;
    flags_view.clear_req = `CLR_RESET;
    flags_view.overflow  = ovf_reg;
    flags_view.spare     = `SPARE_VALUE;
  end

  assign count         = count_reg;
  assign flags         = flags_view;
  assign mode_rejected = rej_reg;

endmodule : pulse_counter_channel

// >>> bench/pc_checker.sv
`timescale 1ns/1ps
module pc_checker
  import pulse_counter_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic                          clk_sys,
  input wire logic                          arst_n,
  input wire logic                          pulse_in,
  input wire logic                          run_wr,
  input wire logic                          run_wdata,
  input wire logic                          clear_wr,
  input wire logic                          clear_wdata,
  input wire logic                          ovf_wr,
  input wire logic                          ovf_wdata,
  input wire pulse_counter_pkg::alarm_cfg_t alarm_cfg,
  input wire logic                          clear_latch,
  input wire logic [WIDTH-1:0]              count,
  input wire pulse_counter_pkg::chan_flags_t flags,
  input wire logic                          alarm_out,
  input wire logic                          mode_rejected
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic clr = clear_wr && clear_wdata;
  wire logic viol = count > alarm_cfg.high_limit[WIDTH-1:0] || count < alarm_cfg.low_limit[WIDTH-1:0];
  wire logic latch = alarm_cfg.mode == ALARM_LATCH;
  sequence counted;
    flags.run && $rose(pulse_in) && !clr;
  endsequence
  chk_count_step:
    assert property (counted |=> count == $past(count) + 1'b1) else $error("count step");
  chk_count_hold:
    assert property ($past(arst_n) && !(flags.run && $rose(pulse_in)) && !clr |=> $stable(count)) else $error("count moved");
  chk_clear_zero:
    assert property (clr |=> count == '0) else $error("count not cleared");
  chk_run_write:
    assert property (run_wr |=> flags.run == $past(run_wdata)) else $error("run flag");
  chk_wrap_ovf:
    assert property (counted ##0 &count |=> flags.overflow && count == '0) else $error("wrap");
  chk_ovf_sticky:
    assert property (flags.overflow && !(ovf_wr && !ovf_wdata) |=> flags.overflow) else $error("overflow lost");
  chk_alarm_off:
    assert property (!latch |=> !alarm_out) else $error("alarm in non-latch mode");
  chk_latch_set:
    assert property (latch && viol |=> alarm_out) else $error("alarm not set");
  chk_latch_hold:
    assert property (alarm_out && latch && !clear_latch |=> alarm_out) else $error("latch dropped");
  chk_mode_flag:
    assert property ($past(arst_n) |=> mode_rejected == ($past(alarm_cfg.mode) inside {ALARM_MOMENTARY, ALARM_RSVD}))
      else $error("mode flag");
endmodule : pc_checker

bind pulse_counter_channel pc_checker #(.WIDTH(WIDTH)) pc_checker_i (.*);

// >>> bench/pulse_source.sv
`timescale 1ns/1ps
module pulse_source
(
  // control
  input  wire logic clk_sys,
  input  wire logic enable,
  // pulse line, low between rises
  output logic      pulse_in
);
  initial pulse_in = 1'b0;
  always @(posedge clk_sys)
  begin
    pulse_in <= enable & ~pulse_in;
  end
endmodule : pulse_source

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pulse_counter_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        en = 1'b0;
  logic [2:0]  wr = 3'h0;
  logic        wd = 1'b0;
  logic        clear_latch = 1'b0;
  alarm_cfg_t  cfg = '0;
  logic        pulse_in;
  // short counter so that a wrap is reachable in a few cycles
  localparam int W = 4;
  logic [W-1:0] count;
  chan_flags_t flags;
  logic        alarm_out;
  logic        mode_rejected;
  int          mismatches = 0;
  int          n_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  pulse_source pulse_source_i (.clk_sys(clk_sys), .enable(en), .pulse_in(pulse_in));
  pulse_counter_channel #(.WIDTH(W)) pulse_counter_channel_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .pulse_in(pulse_in),
    .run_wr(wr[0]), .run_wdata(wd), .clear_wr(wr[1]), .clear_wdata(wd), .ovf_wr(wr[2]), .ovf_wdata(wd),
    .alarm_cfg(cfg), .clear_latch(clear_latch), .count(count), .flags(flags), .alarm_out(alarm_out),
    .mode_rejected(mode_rejected));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle write strobe, result visible on return
  task strobe(input logic [2:0] w, input logic d);
    wr = w;
    wd = d;
    @(negedge clk_sys);
    wr = 3'h0;
    @(negedge clk_sys);
  endtask : strobe
  task pulses(input int k);
    en = 1'b1;
    repeat (2 * k) @(negedge clk_sys);
    en = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulses
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (1000) @(posedge clk_sys);
    mismatches++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    chk("count", 32'h0, count);
    chk("flags", 32'h1, 32'(flags));
    pulses(3);
    chk("count", 32'h3, count);
    strobe(3'h1, 1'b0);
    pulses(2);
    chk("stopped", 32'h3, count);
    chk("flags", 32'h0, 32'(flags));
    strobe(3'h1, 1'b1);
    pulses(1);
    chk("resumed", 32'h4, count);
    strobe(3'h6, 1'b0);
    chk("kept", 32'h4, count);
    chk("flags", 32'h1, 32'(flags));
    cfg = {ALARM_LATCH, 32'h3, 32'h0};
    repeat (2) @(negedge clk_sys);
    chk("alarm", 32'h1, 32'(alarm_out));
    strobe(3'h2, 1'b1);
    chk("cleared", 32'h0, count);
    chk("latched", 32'h1, 32'(alarm_out));
    clear_latch = 1'b1;
    @(negedge clk_sys);
    clear_latch = 1'b0;
    @(negedge clk_sys);
    chk("unlatched", 32'h0, 32'(alarm_out));
    cfg.low_limit = 32'h2;
    for (int m = 3; m >= 0; m--)
    begin
      cfg.mode = alarm_mode_t'(m);
      repeat (2) @(negedge clk_sys);
      chk("alarm", 32'(m == 2), 32'(alarm_out));
      chk("rejected", 32'(m % 2), 32'(mode_rejected));
    end
    pulses(15);
    chk("count", 32'hf, count);
    pulses(1);
    chk("wrapped", 32'h0, count);
    chk("flags", 32'h5, 32'(flags));
    strobe(3'h4, 1'b1);
    chk("ovf kept", 32'h5, 32'(flags));
    strobe(3'h4, 1'b0);
    chk("ovf cleared", 32'h1, 32'(flags));
    stop_test;
  end
endmodule : testbench
